/* tof_timer_common.sv */
// output flip-flops with selectable sources and grouped interrupt requests
// assumes apb4 master on ref_clk; timer, event bus and request inputs are
// one-cycle pulses from logic on the same clock
// prdata and pslverr hold from one setup cycle to the next
// byte lanes 2 and 3 are ignored; 8-bit registers use lane 0 only
// Behaviour
// - ff11..15 single select bit: 0 io timer underflow, 1 event bus.
// - ff10 and ff9: codes 00/01 output timer, 10 bus 0, 11 bus 1.
// - ff8: 00 output timer 8, 01 bus 0, 10 bus 1, 11 bus 2.
// - ff7: 0 output timer 7 else bus 0; ff6: timer 6 else bus 1.
// - ff19..17: io timer 8/7/6 for 00/01, bus 0 for 10, bus 1 for 11.
// - ff16: 00 io timer 5, 01 bus 0, 10 bus 1, 11 bus 3.
// - protect 0 lets data writes through, protect 1 blocks them.
// - ff0..15 in the low registers, ff16..20 in the high ones.
// - a permitted data write forces the flip-flop to the written value.
// - otherwise each flip-flop toggles on events from its fixed or selected source.
// - hardware sets request status bits; software can never set them.
// - writing 0 clears a status bit, writing 1 leaves it alone.
// - status bits record requests regardless of the mask bit.
// - mask 0 passes a source to its shared line, mask 1 blocks it.
// - clearing a status bit also drops its pending request.
// - output timer 10 request has no status or mask here.
// - lines 0..4 group io and output timers as listed.
// - lines 6,7,9..12 group output, measure timers and timer inputs.
// - shared lines carry only unmasked requests; they are not writable.
//
// Local design decision: register access over APB.
module tof_timer_common
  import tof_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [10:0] otm_udf,
  input wire logic [9:0] io_timer_udf,
  input wire logic [3:0] oeb_evt,
  input wire logic [9:0] otm_irq,
  input wire logic [9:0] io_timer_irq,
  input wire logic [1:0] meas_irq,
  input wire logic timer_input0_irq,
  input wire logic timer_input3_irq,
  input wire logic [7:0] timer_input16_irq,
  output logic [20:0] ff_out,
  output logic irq_line0,
  output logic irq_line1,
  output logic irq_line2,
  output logic irq_line3,
  output logic irq_line4,
  output logic irq_line6,
  output logic irq_line7,
  output logic irq_line9,
  output logic irq_line10,
  output logic irq_line11,
  output logic irq_line12
);

  // register state
  logic [12:0] sel_lo_ff;
  logic [7:0] sel_hi_ff;
  logic [20:0] prot_ff;
  logic [20:0] ff_out_ff;
  logic [31:0] st_ff;
  logic [31:0] mk_ff;
  logic [31:0] prdata_ff;
  logic pslverr_ff;
  logic [10:0] irq_ff;
  logic [10:0] nxt_irq;

  // decode and datapath nets
  logic [23:0] idx;
  logic addr_ok;
  logic hit;
  logic [31:0] rd_mux;
  logic wr_acc;
  logic lane0;
  logic lane1;
  logic [15:0] wmask;
  logic [20:0] ff_evt;
  logic [20:0] ff_force;
  logic [20:0] ff_wval;
  logic [31:0] st_clr;
  logic [31:0] mk_we;
  logic [31:0] mk_wv;
  logic [31:0] src_req;
  logic [31:0] live;

  assign idx = paddr[25:2];
  assign addr_ok = (paddr[31:26] == 6'h00) && (paddr[1:0] == 2'h0);
  assign lane0 = pstrb[0];
  assign lane1 = pstrb[1];
  assign wmask = {{8{lane1}}, {8{lane0}}};
  // zero-wait slave: the access phase always completes in one cycle
  assign pready = 1'b1;
  assign wr_acc = psel && penable && pwrite && !pslverr_ff;
  assign prdata = prdata_ff;
  assign pslverr = pslverr_ff;
  assign ff_out = ff_out_ff;

  // request order matches the status and mask bit numbering
  assign src_req = {timer_input16_irq, timer_input3_irq, timer_input0_irq, meas_irq,
                    io_timer_irq, otm_irq};

  // address decode and read mux; unmapped indices answer with an error
  always_comb begin
    hit = addr_ok;
    rd_mux = 32'h00000000;
    unique case (idx)
      TOF_IDX_SEL_LO: rd_mux = {19'h00000, sel_lo_ff};
      TOF_IDX_SEL_HI: rd_mux = {24'h000000, sel_hi_ff};
      TOF_IDX_PROT_LO: rd_mux = {16'h0000, prot_ff[15:0]};
      TOF_IDX_DATA_LO: rd_mux = {16'h0000, ff_out_ff[15:0]};
      // narrow registers read back zero above their fields
      TOF_IDX_PROT_HI: rd_mux = {27'h0000000, prot_ff[20:16]};
      TOF_IDX_DATA_HI: rd_mux = {27'h0000000, ff_out_ff[20:16]};
      TOF_IDX_OTM_ST: rd_mux = {26'h0000000, st_ff[5:0]};
      TOF_IDX_OTM_MK: rd_mux = {26'h0000000, mk_ff[5:0]};
      TOF_IDX_OTM_P67: rd_mux = {26'h0000000, st_ff[7:6], 2'h0, mk_ff[7:6]};
      TOF_IDX_OTM_P89: rd_mux = {26'h0000000, st_ff[9:8], 2'h0, mk_ff[9:8]};
      TOF_IDX_IOT_Q03: rd_mux = {24'h000000, st_ff[13:10], mk_ff[13:10]};
      TOF_IDX_IOT_Q47: rd_mux = {24'h000000, st_ff[17:14], mk_ff[17:14]};
      TOF_IDX_IOT_P89: rd_mux = {26'h0000000, st_ff[19:18], 2'h0, mk_ff[19:18]};
      TOF_IDX_MEAS_P: rd_mux = {26'h0000000, st_ff[21:20], 2'h0, mk_ff[21:20]};
      TOF_IDX_TIN_S0: rd_mux = {27'h0000000, st_ff[22], 3'h0, mk_ff[22]};
      TOF_IDX_TIN_S3: rd_mux = {27'h0000000, st_ff[23], 3'h0, mk_ff[23]};
      TOF_IDX_TIN_Q16: rd_mux = {24'h000000, st_ff[27:24], mk_ff[27:24]};
      TOF_IDX_TIN_Q20: rd_mux = {24'h000000, st_ff[31:28], mk_ff[31:28]};
      default: hit = 1'b0;
    endcase
  end

  // read data and error are captured in the setup cycle, so both come from flops
  // a write cycle or a refused access returns zero read data
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata_ff <= 32'h00000000;
      pslverr_ff <= 1'b0;
    end else if (psel && !penable) begin
      prdata_ff <= (hit && !pwrite) ? rd_mux : 32'h00000000;
      pslverr_ff <= !hit;
    end
  end

  // source select registers; byte lanes honoured, halfword writes expected
  // the low select register has no bits above 12, so they read as zero
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sel_lo_ff <= TOF_SEL_LO_RST;
      sel_hi_ff <= TOF_SEL_HI_RST;
    end else if (wr_acc) begin
      if (idx == TOF_IDX_SEL_LO) begin
        sel_lo_ff <= (sel_lo_ff & ~wmask[12:0]) | (pwdata[12:0] & wmask[12:0]);
      end
      if (idx == TOF_IDX_SEL_HI && lane0) begin
        sel_hi_ff <= pwdata[7:0];
      end
    end
  end

  // protect bits gate software data writes only, never events
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      prot_ff <= TOF_PROT_RST;
    end else if (wr_acc) begin
      if (idx == TOF_IDX_PROT_LO) begin
        prot_ff[15:0] <= (prot_ff[15:0] & ~wmask) | (pwdata[15:0] & wmask);
      end
      if (idx == TOF_IDX_PROT_HI && lane0) begin
        prot_ff[20:16] <= pwdata[4:0];
      end
    end
  end

  // event routing from timer underflows and output event buses
  always_comb begin
    // ff0..5 have no selector and follow their own output timers
    ff_evt[5:0] = otm_udf[5:0];
    ff_evt[6] = sel_lo_ff[0] ? oeb_evt[1] : otm_udf[6];
    ff_evt[7] = sel_lo_ff[1] ? oeb_evt[0] : otm_udf[7];
    unique case (tof_sel2_t'(sel_lo_ff[3:2]))
      TOF_SEL2_TIMER: ff_evt[8] = otm_udf[8];
      TOF_SEL2_BUS_A: ff_evt[8] = oeb_evt[0];
      TOF_SEL2_BUS_B: ff_evt[8] = oeb_evt[1];
      TOF_SEL2_BUS_C: ff_evt[8] = oeb_evt[2];
    endcase
    // high code bit picks a bus, low bit says which of bus 0 or 1
    ff_evt[9] = sel_lo_ff[5] ? oeb_evt[sel_lo_ff[4]] : otm_udf[9];
    ff_evt[10] = sel_lo_ff[7] ? oeb_evt[sel_lo_ff[6]] : otm_udf[10];
    ff_evt[11] = sel_lo_ff[8] ? oeb_evt[1] : io_timer_udf[0];
    ff_evt[12] = sel_lo_ff[9] ? oeb_evt[2] : io_timer_udf[1];
    ff_evt[13] = sel_lo_ff[10] ? oeb_evt[3] : io_timer_udf[2];
    ff_evt[14] = sel_lo_ff[11] ? oeb_evt[0] : io_timer_udf[3];
    ff_evt[15] = sel_lo_ff[12] ? oeb_evt[0] : io_timer_udf[4];
    // ff16 decodes like ff8, but its last code picks bus 3
    unique case (tof_sel2_t'(sel_hi_ff[1:0]))
      TOF_SEL2_TIMER: ff_evt[16] = io_timer_udf[5];
      TOF_SEL2_BUS_A: ff_evt[16] = oeb_evt[0];
      TOF_SEL2_BUS_B: ff_evt[16] = oeb_evt[1];
      TOF_SEL2_BUS_C: ff_evt[16] = oeb_evt[3];
    endcase
    ff_evt[17] = sel_hi_ff[3] ? oeb_evt[sel_hi_ff[2]] : io_timer_udf[6];
    ff_evt[18] = sel_hi_ff[5] ? oeb_evt[sel_hi_ff[4]] : io_timer_udf[7];
    ff_evt[19] = sel_hi_ff[7] ? oeb_evt[sel_hi_ff[6]] : io_timer_udf[8];
    // ff20 has no selectable source: it follows io timer 9
    ff_evt[20] = io_timer_udf[9];
  end

  // data register writes, gated per bit by the protect bits
  // the high data register has a single lane, so lane 0 alone enables it
  always_comb begin
    ff_force = 21'h000000;
    ff_wval = 21'h000000;
    if (wr_acc && idx == TOF_IDX_DATA_LO) begin
      ff_force[15:0] = wmask & ~prot_ff[15:0];
      ff_wval[15:0] = pwdata[15:0];
    end
    if (wr_acc && idx == TOF_IDX_DATA_HI && lane0) begin
      ff_force[20:16] = ~prot_ff[20:16];
      ff_wval[20:16] = pwdata[4:0];
    end
  end

  // one flop per output so each bit keeps its own write and toggle path
  for (genvar i = 0; i < TOF_NUM_FF; i++) begin : g_ff
    always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
        ff_out_ff[i] <= TOF_DATA_RST[i];
      end else if (ff_force[i]) begin
        // software write wins over a coincident event
        ff_out_ff[i] <= ff_wval[i];
      end else if (ff_evt[i]) begin
        ff_out_ff[i] <= ~ff_out_ff[i];
      end
    end
  end

  // grouping register writes: status bits clear on 0, mask bits store
  // only lane 0 matters here; every grouping register is 8 bits wide
  always_comb begin
    st_clr = 32'h00000000;
    mk_we = 32'h00000000;
    mk_wv = 32'h00000000;
    if (wr_acc && lane0) begin
      unique case (idx)
        // output timers 0..5 keep status and mask in separate registers
        TOF_IDX_OTM_ST: st_clr[5:0] = ~pwdata[5:0];
        TOF_IDX_OTM_MK: begin
          mk_we[5:0] = 6'h3f;
          mk_wv[5:0] = pwdata[5:0];
        end
        TOF_IDX_OTM_P67: begin
          st_clr[7:6] = ~pwdata[TOF_PAIR_ST+1:TOF_PAIR_ST];
          mk_we[7:6] = 2'h3;
          mk_wv[7:6] = pwdata[1:0];
        end
        TOF_IDX_OTM_P89: begin
          st_clr[9:8] = ~pwdata[TOF_PAIR_ST+1:TOF_PAIR_ST];
          mk_we[9:8] = 2'h3;
          mk_wv[9:8] = pwdata[1:0];
        end
        TOF_IDX_IOT_Q03: begin
          st_clr[13:10] = ~pwdata[TOF_QUAD_ST+3:TOF_QUAD_ST];
          mk_we[13:10] = 4'hf;
          mk_wv[13:10] = pwdata[3:0];
        end
        TOF_IDX_IOT_Q47: begin
          st_clr[17:14] = ~pwdata[TOF_QUAD_ST+3:TOF_QUAD_ST];
          mk_we[17:14] = 4'hf;
          mk_wv[17:14] = pwdata[3:0];
        end
        TOF_IDX_IOT_P89: begin
          st_clr[19:18] = ~pwdata[TOF_PAIR_ST+1:TOF_PAIR_ST];
          mk_we[19:18] = 2'h3;
          mk_wv[19:18] = pwdata[1:0];
        end
        TOF_IDX_MEAS_P: begin
          st_clr[21:20] = ~pwdata[TOF_PAIR_ST+1:TOF_PAIR_ST];
          mk_we[21:20] = 2'h3;
          mk_wv[21:20] = pwdata[1:0];
        end
        TOF_IDX_TIN_S0: begin
          st_clr[22] = ~pwdata[TOF_SGL_ST];
          mk_we[22] = 1'b1;
          mk_wv[22] = pwdata[0];
        end
        TOF_IDX_TIN_S3: begin
          st_clr[23] = ~pwdata[TOF_SGL_ST];
          mk_we[23] = 1'b1;
          mk_wv[23] = pwdata[0];
        end
        TOF_IDX_TIN_Q16: begin
          st_clr[27:24] = ~pwdata[TOF_QUAD_ST+3:TOF_QUAD_ST];
          mk_we[27:24] = 4'hf;
          mk_wv[27:24] = pwdata[3:0];
        end
        TOF_IDX_TIN_Q20: begin
          st_clr[31:28] = ~pwdata[TOF_QUAD_ST+3:TOF_QUAD_ST];
          mk_we[31:28] = 4'hf;
          mk_wv[31:28] = pwdata[3:0];
        end
        default: st_clr = 32'h00000000;
      endcase
    end
  end

  // set beats clear so a request landing on the clearing write is kept;
  // clearing an unserviced bit silently drops that request
  // a source held high re-sets its bit on every cycle
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff <= TOF_ST_RST;
    end else begin
      st_ff <= src_req | (st_ff & ~st_clr);
    end
  end

  // mask bits are plain storage; a masked source still records status
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      mk_ff <= TOF_MK_RST;
    end else begin
      mk_ff <= (mk_ff & ~mk_we) | (mk_wv & mk_we);
    end
  end

  // a set mask hides a source from its line but not from polling
  assign live = st_ff & ~mk_ff;

  // output timer 10 request bypasses this block entirely
  always_comb begin
    // each line ors the live bits of its own group
    nxt_irq[0] = |live[13:10];
    nxt_irq[1] = |live[7:6];
    nxt_irq[2] = |live[5:0];
    nxt_irq[3] = |live[19:18];
    nxt_irq[4] = |live[17:14];
    nxt_irq[5] = |live[9:8];
    nxt_irq[6] = |live[21:20];
    nxt_irq[7] = live[22];
    nxt_irq[8] = |live[27:24];
    nxt_irq[9] = |live[31:28];
    nxt_irq[10] = live[23];
  end

  // registered lines cost a cycle but give the controller glitch-free inputs
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_ff <= 11'h000;
    end else begin
      irq_ff <= nxt_irq;
    end
  end

  // lines 5 and 8 are not produced here
  assign irq_line0 = irq_ff[0];
  assign irq_line1 = irq_ff[1];
  assign irq_line2 = irq_ff[2];
  assign irq_line3 = irq_ff[3];
  assign irq_line4 = irq_ff[4];
  assign irq_line6 = irq_ff[5];
  assign irq_line7 = irq_ff[6];
  assign irq_line9 = irq_ff[7];
  assign irq_line10 = irq_ff[8];
  assign irq_line11 = irq_ff[9];
  assign irq_line12 = irq_ff[10];

endmodule

/* tof_pkg.sv */
// constants for the timer output flip-flop and interrupt grouping block
// assumes a 32-bit apb bus where each register index maps to byte address index*4
package tof_pkg;

  localparam int TOF_NUM_FF = 21;
  localparam int TOF_NUM_SRC = 32;
  localparam int TOF_IDX_W = 24;

  // register indices; byte address is four times the index
  localparam logic [23:0] TOF_IDX_SEL_LO = 24'h800220;
  localparam logic [23:0] TOF_IDX_SEL_HI = 24'h800223;
  localparam logic [23:0] TOF_IDX_PROT_LO = 24'h800224;
  localparam logic [23:0] TOF_IDX_DATA_LO = 24'h800226;
  localparam logic [23:0] TOF_IDX_PROT_HI = 24'h800229;
  localparam logic [23:0] TOF_IDX_DATA_HI = 24'h80022b;
  localparam logic [23:0] TOF_IDX_OTM_ST = 24'h800230;
  localparam logic [23:0] TOF_IDX_OTM_MK = 24'h800231;
  localparam logic [23:0] TOF_IDX_OTM_P67 = 24'h800232;
  localparam logic [23:0] TOF_IDX_OTM_P89 = 24'h800233;
  localparam logic [23:0] TOF_IDX_IOT_Q03 = 24'h800234;
  localparam logic [23:0] TOF_IDX_IOT_Q47 = 24'h800235;
  localparam logic [23:0] TOF_IDX_IOT_P89 = 24'h800236;
  localparam logic [23:0] TOF_IDX_MEAS_P = 24'h800237;
  localparam logic [23:0] TOF_IDX_TIN_S0 = 24'h800238;
  localparam logic [23:0] TOF_IDX_TIN_S3 = 24'h800239;
  localparam logic [23:0] TOF_IDX_TIN_Q16 = 24'h80023c;
  localparam logic [23:0] TOF_IDX_TIN_Q20 = 24'h80023d;

  // source numbering inside the status and mask vectors
  localparam int TOF_SRC_OTM = 0;
  localparam int TOF_SRC_IOT = 10;
  localparam int TOF_SRC_MEAS = 20;
  localparam int TOF_SRC_TIN0 = 22;
  localparam int TOF_SRC_TIN3 = 23;
  localparam int TOF_SRC_TIN16 = 24;
  localparam int TOF_SRC_TIN20 = 28;

  // field positions inside the 8-bit grouping registers
  localparam int TOF_QUAD_ST = 4;
  localparam int TOF_PAIR_ST = 4;
  localparam int TOF_SGL_ST = 4;

  localparam logic [12:0] TOF_SEL_LO_RST = 13'h0000;
  localparam logic [7:0] TOF_SEL_HI_RST = 8'h00;
  localparam logic [20:0] TOF_PROT_RST = 21'h000000;
  localparam logic [20:0] TOF_DATA_RST = 21'h000000;
  localparam logic [31:0] TOF_ST_RST = 32'h00000000;
  localparam logic [31:0] TOF_MK_RST = 32'h00000000;

  typedef enum logic [1:0] {
    TOF_SEL2_TIMER,
    TOF_SEL2_BUS_A,
    TOF_SEL2_BUS_B,
    TOF_SEL2_BUS_C
  } tof_sel2_t;

endpackage

/* tof_timer_common_props.sv */
// checker for the output flip-flop and grouped request block
// sees only top ports; sources are one-cycle pulses on ref_clk
module tof_timer_common_props (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic [10:0] otm_udf,
  input wire logic [9:0] io_timer_udf,
  input wire logic [3:0] oeb_evt,
  input wire logic [9:0] otm_irq,
  input wire logic [9:0] io_timer_irq,
  input wire logic timer_input0_irq,
  input wire logic timer_input3_irq,
  input wire logic [7:0] timer_input16_irq,
  input wire logic [20:0] ff_out,
  input wire logic irq_line0,
  input wire logic irq_line1,
  input wire logic irq_line2,
  input wire logic irq_line9,
  input wire logic irq_line10,
  input wire logic irq_line12
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  logic wr;
  logic evt;
  assign wr = psel & penable & pwrite;
  assign evt = |{otm_udf, io_timer_udf, oeb_evt};
  // lines are registered, so a cause shows two samples back
  a_ff_cause: assert property (!$stable(ff_out) |-> $past(evt | wr))
    else $error("flip-flop moved without event or write");
  a_line0_src: assert property ($rose(irq_line0) |-> $past(|io_timer_irq[3:0] | wr, 2))
    else $error("line 0 rose without its sources");
  a_line2_src: assert property ($rose(irq_line2) |-> $past(|otm_irq[5:0] | wr, 2))
    else $error("line 2 rose without its sources");
  a_line10_src: assert property ($rose(irq_line10) |-> $past(|timer_input16_irq[3:0] | wr, 2))
    else $error("line 10 rose without its sources");
  a_line9_cause: assert property (!$stable(irq_line9) |-> $past(timer_input0_irq | wr, 2))
    else $error("line 9 moved without cause");
  a_line12_cause: assert property (!$stable(irq_line12) |-> $past(timer_input3_irq | wr, 2))
    else $error("line 12 moved without cause");
  a_line1_fall: assert property ($fell(irq_line1) |-> $past(wr, 2))
    else $error("line 1 fell without a write");
  a_no_otm10_reg: assert property (psel && !penable && paddr == 32'h02000884 |=> pslverr)
    else $error("hole in the map answered without error");
  a_narrow_read: assert property (psel && !penable && !pwrite && paddr == 32'h0200088c
    |=> prdata[31:8] == 24'h0)
    else $error("upper bits of 8-bit register not zero");
  c_line1: cover property ($rose(irq_line1));
  c_ff_move: cover property (!$stable(ff_out));
  c_err: cover property (pslverr);
endmodule

bind tof_timer_common tof_timer_common_props tof_timer_common_props_inst (.*);

/* tof_src_model.sv */
// far side: timer channels, event buses and request sources
// each source fires a one-cycle pulse launched right after an edge
module tof_src_model (
  input wire logic ref_clk,
  output logic [10:0] otm_udf,
  output logic [9:0] io_timer_udf,
  output logic [3:0] oeb_evt,
  output logic [9:0] otm_irq,
  output logic [9:0] io_timer_irq,
  output logic [1:0] meas_irq,
  output logic timer_input0_irq,
  output logic timer_input3_irq,
  output logic [7:0] timer_input16_irq
);
  logic [56:0] p = '0;
  assign {timer_input16_irq, timer_input3_irq, timer_input0_irq, meas_irq, io_timer_irq,
    otm_irq, oeb_evt, io_timer_udf, otm_udf} = p;
  // a held level would keep re-setting status, so always drop after one cycle
  task automatic pulse(input int n);
    @(posedge ref_clk);
    p[n] <= 1'b1;
    @(posedge ref_clk);
    p <= '0;
  endtask
endmodule

/* tof_timer_common_tb.sv */
// self-checking bench for the output flip-flop and grouped request block
// drives apb by hand; the source model makes timer and request pulses
module tof_timer_common_tb
  import tof_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [3:0] pstrb = 4'h3;
  logic [31:0] prdata;
  logic pready, pslverr;
  logic [10:0] otm_udf;
  logic [9:0] io_timer_udf, otm_irq, io_timer_irq;
  logic [3:0] oeb_evt;
  logic [1:0] meas_irq;
  logic timer_input0_irq, timer_input3_irq;
  logic [7:0] timer_input16_irq;
  logic [20:0] ff_out;
  logic irq_line0, irq_line1, irq_line2, irq_line3, irq_line4, irq_line6;
  logic irq_line7, irq_line9, irq_line10, irq_line11, irq_line12;
  logic [12:0] lines;
  int n_errors = 0;
  int n_compared = 0;
  int cyc = 0;
  logic [31:0] rd;
  logic err;
  logic [20:0] exp_ff;
  assign lines = {irq_line12, irq_line11, irq_line10, irq_line9, 1'b0, irq_line7, irq_line6,
    1'b0, irq_line4, irq_line3, irq_line2, irq_line1, irq_line0};
  tof_timer_common tof_timer_common_inst (.*);
  tof_src_model tof_src_model_inst (.*);
  always #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      test_done();
    end
  end
  task automatic test_done();
    if (n_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // halfword lanes only, held until pready is seen
  task automatic apb(input logic w, input logic [23:0] idx, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {6'h0, idx, 2'b00};
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic settle();
    @(posedge ref_clk);
    #1;
  endtask
  task automatic t_reset();
    logic [23:0] idx [7] = '{TOF_IDX_SEL_LO, TOF_IDX_SEL_HI, TOF_IDX_PROT_LO,
      TOF_IDX_DATA_LO, TOF_IDX_PROT_HI, TOF_IDX_DATA_HI, TOF_IDX_OTM_ST};
    chk(32'(ff_out), 32'h0);
    chk(32'(lines), 32'h0);
    foreach (idx[i]) begin
      apb(1'b0, idx[i], '0);
      chk(rd, 32'h0);
    end
  endtask
  task automatic t_data();
    apb(1'b1, TOF_IDX_DATA_LO, 32'ha5c3);
    settle();
    chk(32'(ff_out), 32'h00a5c3);
    apb(1'b1, TOF_IDX_PROT_LO, 32'h00ff);
    apb(1'b1, TOF_IDX_DATA_LO, 32'h0);
    settle();
    chk(32'(ff_out), 32'h0000c3);
    apb(1'b1, TOF_IDX_PROT_HI, 32'h10);
    apb(1'b1, TOF_IDX_DATA_HI, 32'h1f);
    settle();
    chk(32'(ff_out), 32'h0f00c3);
    apb(1'b0, TOF_IDX_DATA_HI, '0);
    chk(rd, 32'h0f);
    apb(1'b0, TOF_IDX_PROT_LO, '0);
    chk(rd, 32'h00ff);
    apb(1'b1, TOF_IDX_PROT_LO, '0);
    apb(1'b1, TOF_IDX_PROT_HI, '0);
    apb(1'b1, TOF_IDX_DATA_LO, '0);
    apb(1'b1, TOF_IDX_DATA_HI, '0);
    settle();
    chk(32'(ff_out), 32'h0);
    exp_ff = '0;
  endtask
  // select low, select high, flip-flop, source bit of the model
  task automatic t_select();
    logic [31:0] cs [21] = '{{13'h1000, 8'h0, 5'd15, 6'd21}, {13'h0, 8'h0, 5'd14, 6'd14},
      {13'h0400, 8'h0, 5'd13, 6'd24}, {13'h0, 8'h0, 5'd12, 6'd12},
      {13'h0100, 8'h0, 5'd11, 6'd22}, {13'h0040, 8'h0, 5'd10, 6'd10},
      {13'h0080, 8'h0, 5'd10, 6'd21}, {13'h00c0, 8'h0, 5'd10, 6'd22},
      {13'h0020, 8'h0, 5'd9, 6'd21}, {13'h0030, 8'h0, 5'd9, 6'd22},
      {13'h0, 8'h0, 5'd8, 6'd8}, {13'h0004, 8'h0, 5'd8, 6'd21},
      {13'h0008, 8'h0, 5'd8, 6'd22}, {13'h000c, 8'h0, 5'd8, 6'd23},
      {13'h0002, 8'h0, 5'd7, 6'd21}, {13'h0001, 8'h0, 5'd6, 6'd22},
      {13'h0, 8'h04, 5'd17, 6'd17}, {13'h0, 8'h08, 5'd17, 6'd21},
      {13'h0, 8'hc0, 5'd19, 6'd22}, {13'h0, 8'h03, 5'd16, 6'd24},
      {13'h0, 8'h0, 5'd16, 6'd16}};
    foreach (cs[i]) begin
      apb(1'b1, TOF_IDX_SEL_LO, 32'(cs[i][31:19]));
      apb(1'b1, TOF_IDX_SEL_HI, 32'(cs[i][18:11]));
      tof_src_model_inst.pulse(int'(cs[i][5:0]));
      settle();
      exp_ff[cs[i][10:6]] = ~exp_ff[cs[i][10:6]];
      chk(32'(ff_out), 32'(exp_ff));
    end
  endtask
  // data write and ff8 timer event land on the same access edge
  task automatic t_race();
    fork
      apb(1'b1, TOF_IDX_DATA_LO, 32'(exp_ff[15:0]));
      begin
        @(posedge ref_clk);
        tof_src_model_inst.pulse(8);
      end
    join
    settle();
    chk(32'(ff_out), 32'(exp_ff));
  endtask
  // register, line number, source bit of the model
  task automatic t_irq();
    logic [33:0] gs [10] = '{{TOF_IDX_IOT_Q03, 4'd0, 6'd37}, {TOF_IDX_OTM_ST, 4'd2, 6'd28},
      {TOF_IDX_IOT_P89, 4'd3, 6'd44}, {TOF_IDX_IOT_Q47, 4'd4, 6'd40},
      {TOF_IDX_OTM_P89, 4'd6, 6'd33}, {TOF_IDX_MEAS_P, 4'd7, 6'd46},
      {TOF_IDX_TIN_S0, 4'd9, 6'd47}, {TOF_IDX_TIN_Q16, 4'd10, 6'd50},
      {TOF_IDX_TIN_Q20, 4'd11, 6'd55}, {TOF_IDX_TIN_S3, 4'd12, 6'd48}};
    tof_src_model_inst.pulse(31);
    settle();
    chk(32'(lines), 32'h2);
    apb(1'b0, TOF_IDX_OTM_P67, '0);
    chk(rd, 32'h10);
    apb(1'b1, TOF_IDX_OTM_P67, 32'h33);
    settle();
    chk(32'(lines), 32'h0);
    apb(1'b0, TOF_IDX_OTM_P67, '0);
    chk(rd, 32'h13);
    tof_src_model_inst.pulse(32);
    settle();
    chk(32'(lines), 32'h0);
    apb(1'b0, TOF_IDX_OTM_P67, '0);
    chk(rd, 32'h33);
    apb(1'b1, TOF_IDX_OTM_P67, 32'h20);
    settle();
    chk(32'(lines), 32'h2);
    apb(1'b0, TOF_IDX_OTM_P67, '0);
    chk(rd, 32'h20);
    apb(1'b1, TOF_IDX_OTM_P67, '0);
    settle();
    chk(32'(lines), 32'h0);
    foreach (gs[i]) begin
      tof_src_model_inst.pulse(int'(gs[i][5:0]));
      settle();
      chk(32'(lines), 32'h1 << gs[i][9:6]);
      apb(1'b1, gs[i][33:10], '0);
      settle();
      chk(32'(lines), 32'h0);
    end
  endtask
  task automatic t_unmapped();
    apb(1'b0, 24'h800221, '0);
    chk(rd, 32'h0);
    chk(32'(err), 32'h1);
    apb(1'b1, 24'h800221, 32'hff);
    chk(32'(err), 32'h1);
  endtask
  initial begin
    repeat (8) @(posedge ref_clk);
    reset_n <= 1'b1;
    t_reset();
    t_data();
    t_select();
    t_race();
    t_irq();
    t_unmapped();
    test_done();
  end
endmodule
